// ---- hdl/tctf_fabric.sv ----
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module tctf_fabric
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// register bus write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// register bus read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// clock sources, sampled as levels
	input  wire logic        externalTimerClock,
	input  wire logic        auxClock,
	input  wire logic        subsystemClock,
	input  wire logic        touchBlockClock,
	// capture and trigger pins
	input  wire logic        ch1PinGroup0,
	input  wire logic        ch1PinGroup1,
	input  wire logic        ch2PinGroup0,
	input  wire logic        ch2PinGroup1,
	input  wire logic        comparatorOutput,
	input  wire logic        hizTriggerPin,
	input  wire logic        touchCapture,
	// same-domain peripheral signals
	input  wire logic [3:0]  pinFunctionSelect,
	input  wire logic        serialTxData,
	// pads and events
	output logic      [3:0]  padOut,
	output logic      [3:0]  padOutEnable,
	output logic             irTxOut,
	output logic             convTrigger,
	output logic             wakeEvent,
	output logic             irq
);

	function automatic logic [31:0] mergeStrb(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = data[i*8 +: 8];
		return res;
	endfunction

	function automatic tctf_pkg::tctf_mode_type decodeMode(
		input logic [1:0] f);
		tctf_pkg::tctf_mode_type m;
		case (f)
			tctf_pkg::MODEF_UP:   m = tctf_pkg::MODE_UP;
			tctf_pkg::MODEF_CONT: m = tctf_pkg::MODE_CONT;
			default:              m = tctf_pkg::MODE_STOP;
		endcase
		return m;
	endfunction

	localparam int AW = tctf_pkg::ASYNC_W;

	logic [AW-1:0] syncA_reg;
	logic [AW-1:0] syncB_reg;
	logic [AW-1:0] prevB_reg;
	logic [AW-1:0] rise;
	logic [AW-1:0] rawIn;

	logic [tctf_pkg::CTRL_W-1:0] ctrl_reg;
	logic [tctf_pkg::IR_W-1:0]   ircfg_reg;
	logic [tctf_pkg::CC_W-1:0]   cctl_reg [3];
	logic [15:0]                 wakeMod_reg;
	logic [15:0]                 wakeCnt_reg;
	logic [15:0]                 count_reg;
	logic [tctf_pkg::IRQ_W-1:0]  irqStat_reg;
	logic [tctf_pkg::IRQ_W-1:0]  irqMask_reg;
	logic [tctf_pkg::IRQ_W-1:0]  irqEvents;
	logic [tctf_pkg::IRQ_W-1:0]  irqClear;
	logic [3:0]                  oe_reg;
	logic                        swStart_reg;
	logic                        hizPrev_reg;

	logic        wrFire;
	logic        rdFire;
	logic [31:0] wrWord;
	logic [31:0] rdData;
	logic        rdHit;
	logic        wrHit;

	logic        tick;
	logic        wrapPulse;
	logic        wakeTick;
	logic        wakeOvf;
	logic        hizActive;
	logic        remap;
	logic [15:0] ccr [3];
	logic [2:0]  ccEvent;
	logic [2:0]  ccOut;
	logic [2:0]  ccrWrite;
	logic [2:0]  capA;
	logic [2:0]  capB;
	logic        ir_software_data;
	logic        irMod;
	logic        convNext;

	tctf_pkg::tctf_mode_type mode;

	// every clock source and capture or trigger pin passes two flops before use
	assign rawIn = {touchCapture, hizTriggerPin, comparatorOutput,
		ch2PinGroup1, ch2PinGroup0, ch1PinGroup1, ch1PinGroup0,
		touchBlockClock, subsystemClock, auxClock, externalTimerClock};

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			syncA_reg <= '0;
			syncB_reg <= '0;
			prevB_reg <= '0;
		end
		else
		begin
			syncA_reg <= rawIn;
			syncB_reg <= syncA_reg;
			prevB_reg <= syncB_reg;
		end
	end

	assign rise = syncB_reg & ~prevB_reg;

	// register bus: write taken once address and data are both offered
	assign wrFire = s_axi_awready;
	assign rdFire = s_axi_arready;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= s_axi_awvalid & s_axi_wvalid
				& ~s_axi_awready & ~s_axi_bvalid;
			s_axi_wready <= s_axi_awvalid & s_axi_wvalid
				& ~s_axi_awready & ~s_axi_bvalid;
		end
	end

	always_comb
	begin
		case (s_axi_awaddr)
			tctf_pkg::OFS_CTRL, tctf_pkg::OFS_IRCFG, tctf_pkg::OFS_CCTL0,
			tctf_pkg::OFS_CCTL1, tctf_pkg::OFS_CCTL2, tctf_pkg::OFS_CHANNEL_ZERO_COMPARE,
			tctf_pkg::OFS_CCR1, tctf_pkg::OFS_CCR2, tctf_pkg::OFS_WAKEMOD,
			tctf_pkg::OFS_IRQSTAT, tctf_pkg::OFS_IRQMASK:
				wrHit = 1'b1;
			default:
				wrHit = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tctf_pkg::RESP_OKAY;
		end
		else if (wrFire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wrHit ? tctf_pkg::RESP_OKAY
				: tctf_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	function automatic logic [31:0] readWord(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h00000000;
		case (a)
			tctf_pkg::OFS_CTRL:    r[tctf_pkg::CTRL_W-1:0] = ctrl_reg;
			tctf_pkg::OFS_IRCFG:   r[tctf_pkg::IR_W-1:0] = ircfg_reg;
			tctf_pkg::OFS_CCTL0:   r[tctf_pkg::CC_W-1:0] = cctl_reg[0];
			tctf_pkg::OFS_CCTL1:   r[tctf_pkg::CC_W-1:0] = cctl_reg[1];
			tctf_pkg::OFS_CCTL2:   r[tctf_pkg::CC_W-1:0] = cctl_reg[2];
			tctf_pkg::OFS_CHANNEL_ZERO_COMPARE:    r[15:0] = ccr[0];
			tctf_pkg::OFS_CCR1:    r[15:0] = ccr[1];
			tctf_pkg::OFS_CCR2:    r[15:0] = ccr[2];
			tctf_pkg::OFS_COUNT:   r[15:0] = count_reg;
			tctf_pkg::OFS_WAKEMOD: r[15:0] = wakeMod_reg;
			tctf_pkg::OFS_WAKECNT: r[15:0] = wakeCnt_reg;
			tctf_pkg::OFS_IRQSTAT: r[tctf_pkg::IRQ_W-1:0] = irqStat_reg;
			tctf_pkg::OFS_IRQMASK: r[tctf_pkg::IRQ_W-1:0] = irqMask_reg;
			default:               r = 32'h00000000;
		endcase
		return r;
	endfunction

	// a process, not an assign, so register changes also refresh it
	always_comb
	begin
		rdData = readWord(s_axi_araddr);
	end
	assign rdHit = (s_axi_araddr <= tctf_pkg::OFS_IRQMASK)
		& (s_axi_araddr[1:0] == 2'h0);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= tctf_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready
				& ~s_axi_rvalid;
			if (rdFire)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdData;
				s_axi_rresp <= rdHit ? tctf_pkg::RESP_OKAY
					: tctf_pkg::RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// byte-lane merge of the addressed ctrl, ircfg or wakemod register with the incoming word
	always_comb
	begin
		case (s_axi_awaddr)
			tctf_pkg::OFS_CTRL:
				wrWord = mergeStrb({22'h000000, ctrl_reg}, s_axi_wdata,
					s_axi_wstrb);
			tctf_pkg::OFS_IRCFG:
				wrWord = mergeStrb({27'h0000000, ircfg_reg}, s_axi_wdata,
					s_axi_wstrb);
			default:
				wrWord = mergeStrb({16'h0000, wakeMod_reg}, s_axi_wdata,
					s_axi_wstrb);
		endcase
	end

	// software-writable state
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ctrl_reg <= tctf_pkg::CTRL_RESET;
			ircfg_reg <= tctf_pkg::IR_RESET;
			wakeMod_reg <= tctf_pkg::WAKE_RESET;
			irqMask_reg <= tctf_pkg::MASK_RESET;
			for (int i = 0; i < 3; i++)
				cctl_reg[i] <= tctf_pkg::CC_RESET;
		end
		else if (wrFire)
		begin
			case (s_axi_awaddr)
				tctf_pkg::OFS_CTRL:
					ctrl_reg <= wrWord[tctf_pkg::CTRL_W-1:0];
				tctf_pkg::OFS_IRCFG:
					ircfg_reg <= wrWord[tctf_pkg::IR_W-1:0];
				tctf_pkg::OFS_WAKEMOD:
					wakeMod_reg <= wrWord[15:0];
				tctf_pkg::OFS_IRQMASK:
					if (s_axi_wstrb[0])
						irqMask_reg <= s_axi_wdata[tctf_pkg::IRQ_W-1:0];
				default:
					for (int i = 0; i < 3; i++)
						if (s_axi_awaddr == tctf_pkg::OFS_CCTL0
							+ 8'(4 * i) && s_axi_wstrb[0])
							cctl_reg[i] <= s_axi_wdata[7:0];
			endcase
		end
	end

	// software start is a write-one pulse, not stored
	always_ff @(posedge clk)
	begin
		if (reset)
			swStart_reg <= 1'b0;
		else
			swStart_reg <= wrFire & s_axi_wstrb[1]
				& (s_axi_awaddr == tctf_pkg::OFS_CTRL)
				& s_axi_wdata[tctf_pkg::CTRL_CONVSW_BIT];
	end

	// timer clock is a rising edge of the chosen source
	assign tick = rise[ctrl_reg[tctf_pkg::CTRL_CLKSEL_LSB +: 2]];
	assign mode = decodeMode(ctrl_reg[tctf_pkg::CTRL_MODE_LSB +: 2]);

	always_comb
	begin
		case (mode)
			tctf_pkg::MODE_UP:
				wrapPulse = tick & (count_reg >= ccr[0]);
			tctf_pkg::MODE_CONT:
				wrapPulse = tick & (count_reg == 16'hFFFF);
			default:
				wrapPulse = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			count_reg <= 16'h0000;
		else if (wrapPulse)
			count_reg <= 16'h0000;
		else if (tick && mode != tctf_pkg::MODE_STOP)
			count_reg <= count_reg + 16'h0001;
	end

	// wake-up counter on aux or subsystem clock edges, one at a time
	assign wakeTick = ctrl_reg[tctf_pkg::CTRL_WAKEEN_BIT]
		& (ctrl_reg[tctf_pkg::CTRL_WAKECLK_BIT] ? rise[tctf_pkg::IN_SUBCLK]
		: rise[tctf_pkg::IN_AUXCLK]);
	assign wakeOvf = wakeTick & (wakeCnt_reg >= wakeMod_reg);

	always_ff @(posedge clk)
	begin
		if (reset)
			wakeCnt_reg <= 16'h0000;
		else if (wakeOvf)
			wakeCnt_reg <= 16'h0000;
		else if (wakeTick)
			wakeCnt_reg <= wakeCnt_reg + 16'h0001;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			wakeEvent <= 1'b0;
		else
			wakeEvent <= wakeOvf;
	end

	// capture routing
	assign remap = ctrl_reg[tctf_pkg::CTRL_REMAP_BIT];
	assign capA[0] = wakeEvent;
	assign capB[0] = syncB_reg[tctf_pkg::IN_AUXCLK];
	assign capA[1] = remap ? syncB_reg[tctf_pkg::IN_CH1G1]
		: syncB_reg[tctf_pkg::IN_CH1G0];
	assign capB[1] = syncB_reg[tctf_pkg::IN_COMP];
	assign capA[2] = remap ? syncB_reg[tctf_pkg::IN_CH2G1]
		: syncB_reg[tctf_pkg::IN_CH2G0];
	assign capB[2] = syncB_reg[tctf_pkg::IN_TOUCHCAP];

	for (genvar g = 0; g < 3; g++)
	begin : chan
		assign ccrWrite[g] = wrFire & (s_axi_wstrb[1:0] == 2'h3)
			& (s_axi_awaddr == tctf_pkg::OFS_CHANNEL_ZERO_COMPARE + 8'(4 * g));
		tctf_channel u_channel
		(
			.clk          (clk),
			.reset        (reset),
			.tick         (tick),
			.wrapPulse    (wrapPulse),
			.count        (count_reg),
			.ctl          (cctl_reg[g]),
			.ccrWrite     (ccrWrite[g]),
			.ccrWriteData (s_axi_wdata[15:0]),
			.capA         (capA[g]),
			.capB         (capB[g]),
			.ccrValue     (ccr[g]),
			.eventPulse   (ccEvent[g]),
			.outLevel     (ccOut[g])
		);
	end

	// channel zero output drives no pad
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			padOut <= 4'h0;
			oe_reg <= 4'h0;
		end
		else
		begin
			padOut <= {ccOut[2], ccOut[1], ccOut[2], ccOut[1]};
			oe_reg <= pinFunctionSelect;
		end
	end

	// gated after the flop so the kill needs no timer tick
	assign hizActive = ctrl_reg[tctf_pkg::CTRL_HIZSEL_BIT]
		? syncB_reg[tctf_pkg::IN_HIZPIN]
		: syncB_reg[tctf_pkg::IN_COMP];
	assign padOutEnable = oe_reg & {4{~hizActive}};

	// infrared: ask gates the carrier, fsk picks between two carriers
	assign ir_software_data = (ircfg_reg[tctf_pkg::IR_DSRC_BIT]
		? ircfg_reg[tctf_pkg::IR_DATA_BIT] : serialTxData)
		^ ircfg_reg[tctf_pkg::IR_POL_BIT];
	assign irMod = ircfg_reg[tctf_pkg::IR_MODE_BIT]
		? (ir_software_data ? ccOut[1] : ccOut[2])
		: (ir_software_data & ccOut[1]);

	always_ff @(posedge clk)
	begin
		if (reset)
			irTxOut <= 1'b0;
		else
			irTxOut <= ircfg_reg[tctf_pkg::IR_EN_BIT] ? irMod
				: serialTxData;
	end

	always_comb
	begin
		case (ctrl_reg[tctf_pkg::CTRL_CONV_LSB +: 2])
			tctf_pkg::CONV_SW:   convNext = swStart_reg;
			tctf_pkg::CONV_WAKE: convNext = wakeOvf;
			tctf_pkg::CONV_CH1B: convNext = ccOut[1];
			default:             convNext = syncB_reg[tctf_pkg::IN_COMP];
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			convTrigger <= 1'b0;
		else
			convTrigger <= convNext;
	end

	// interrupts: set wins over a write-one clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (reset)
			hizPrev_reg <= 1'b0;
		else
			hizPrev_reg <= hizActive;
	end

	assign irqEvents = {hizActive & ~hizPrev_reg, wakeOvf,
		ccEvent, wrapPulse};
	assign irqClear = (wrFire && s_axi_wstrb[0]
		&& s_axi_awaddr == tctf_pkg::OFS_IRQSTAT)
		? s_axi_wdata[tctf_pkg::IRQ_W-1:0] : '0;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			irqStat_reg <= '0;
			irq <= 1'b0;
		end
		else
		begin
			irqStat_reg <= (irqStat_reg & ~irqClear) | irqEvents;
			irq <= |(irqStat_reg & irqMask_reg);
		end
	end

endmodule

// ---- hdl/tctf_pkg.sv ----
package tctf_pkg;

	// register byte addresses, one aligned word each
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_IRCFG   = 8'h04;
	localparam logic [7:0] OFS_CCTL0   = 8'h08;
	localparam logic [7:0] OFS_CCTL1   = 8'h0C;
	localparam logic [7:0] OFS_CCTL2   = 8'h10;
	localparam logic [7:0] OFS_CHANNEL_ZERO_COMPARE    = 8'h14;
	localparam logic [7:0] OFS_CCR1    = 8'h18;
	localparam logic [7:0] OFS_CCR2    = 8'h1C;
	localparam logic [7:0] OFS_COUNT   = 8'h20;
	localparam logic [7:0] OFS_WAKEMOD = 8'h24;
	localparam logic [7:0] OFS_WAKECNT = 8'h28;
	localparam logic [7:0] OFS_IRQSTAT = 8'h2C;
	localparam logic [7:0] OFS_IRQMASK = 8'h30;

	// control register fields
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_CLKSEL_LSB = 2;
	localparam int CTRL_REMAP_BIT  = 4;
	localparam int CTRL_HIZSEL_BIT = 5;
	localparam int CTRL_WAKECLK_BIT = 6;
	localparam int CTRL_WAKEEN_BIT = 7;
	localparam int CTRL_CONV_LSB   = 8;
	localparam int CTRL_CONVSW_BIT = 10;
	localparam int CTRL_W          = 10;

	// infrared configuration fields
	localparam int IR_EN_BIT   = 0;
	localparam int IR_POL_BIT  = 1;
	localparam int IR_MODE_BIT = 2;
	localparam int IR_DSRC_BIT = 3;
	localparam int IR_DATA_BIT = 4;
	localparam int IR_W        = 5;

	// channel control fields
	localparam int CC_CAPMODE_BIT = 0;
	localparam int CC_EDGE_LSB    = 1;
	localparam int CC_INSEL_LSB   = 3;
	localparam int CC_OUTMODE_LSB = 5;
	localparam int CC_OUTVAL_BIT  = 7;
	localparam int CC_W           = 8;

	// interrupt status and mask layout
	localparam int IRQ_OVF  = 0;
	localparam int IRQ_CC0  = 1;
	localparam int IRQ_WAKE = 4;
	localparam int IRQ_HIZ  = 5;
	localparam int IRQ_W    = 6;

	// values after reset
	localparam logic [CTRL_W-1:0] CTRL_RESET  = 10'h000;
	localparam logic [IR_W-1:0]   IR_RESET    = 5'h00;
	localparam logic [CC_W-1:0]   CC_RESET    = 8'h00;
	localparam logic [15:0]       CCR_RESET   = 16'h0000;
	localparam logic [15:0]       WAKE_RESET  = 16'hFFFF;
	localparam logic [IRQ_W-1:0]  MASK_RESET  = 6'h00;

	// field encodings
	localparam logic [1:0] MODEF_UP   = 2'h1;
	localparam logic [1:0] MODEF_CONT = 2'h2;
	localparam logic [1:0] CONV_SW    = 2'h0;
	localparam logic [1:0] CONV_WAKE  = 2'h1;
	localparam logic [1:0] CONV_CH1B  = 2'h2;
	localparam logic [1:0] OUT_BIT    = 2'h0;
	localparam logic [1:0] OUT_TOGGLE = 2'h1;
	localparam logic [1:0] OUT_RSTSET = 2'h2;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// asynchronous input vector positions
	localparam int IN_EXTCLK   = 0;
	localparam int IN_AUXCLK   = 1;
	localparam int IN_SUBCLK   = 2;
	localparam int IN_TOUCHCLK = 3;
	localparam int IN_CH1G0    = 4;
	localparam int IN_CH1G1    = 5;
	localparam int IN_CH2G0    = 6;
	localparam int IN_CH2G1    = 7;
	localparam int IN_COMP     = 8;
	localparam int IN_HIZPIN   = 9;
	localparam int IN_TOUCHCAP = 10;
	localparam int ASYNC_W     = 11;

	typedef enum logic [2:0] {
		MODE_STOP = 3'b001,
		MODE_UP   = 3'b010,
		MODE_CONT = 3'b100
	} tctf_mode_type;

endpackage

// ---- hdl/tctf_channel.sv ----
`timescale 1ns/1ps
module tctf_channel
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// counter view
	input  wire logic        tick,
	input  wire logic        wrapPulse,
	input  wire logic [15:0] count,
	// control
	input  wire logic [7:0]  ctl,
	input  wire logic        ccrWrite,
	input  wire logic [15:0] ccrWriteData,
	// capture sources
	input  wire logic        capA,
	input  wire logic        capB,
	// results
	output logic      [15:0] ccrValue,
	output logic             eventPulse,
	output logic             outLevel
);

	logic       capSel;
	logic       capPrev_reg;
	logic       capHit;
	logic       cmpHit;
	logic       captureMode;
	logic [1:0] edgeSel;
	logic [1:0] outMode;

	assign captureMode = ctl[tctf_pkg::CC_CAPMODE_BIT];
	assign edgeSel = ctl[tctf_pkg::CC_EDGE_LSB +: 2];
	assign outMode = ctl[tctf_pkg::CC_OUTMODE_LSB +: 2];

	// inputs A, B, ground, supply
	always_comb
	begin
		case (ctl[tctf_pkg::CC_INSEL_LSB +: 2])
			2'h0:    capSel = capA;
			2'h1:    capSel = capB;
			2'h2:    capSel = 1'b0;
			default: capSel = 1'b1;
		endcase
	end

	assign capHit = captureMode
		& ((edgeSel[0] & capSel & ~capPrev_reg)
		| (edgeSel[1] & ~capSel & capPrev_reg));
	assign cmpHit = ~captureMode & tick & (count == ccrValue);

	always_ff @(posedge clk)
	begin
		if (reset)
			capPrev_reg <= 1'b0;
		else
			capPrev_reg <= capSel;
	end

	// a capture beats a simultaneous software write: it is the hardware event
	always_ff @(posedge clk)
	begin
		if (reset)
			ccrValue <= tctf_pkg::CCR_RESET;
		else if (capHit)
			ccrValue <= count;
		else if (ccrWrite)
			ccrValue <= ccrWriteData;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			eventPulse <= 1'b0;
		else
			eventPulse <= capHit | cmpHit;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			outLevel <= 1'b0;
		else
			case (outMode)
				tctf_pkg::OUT_BIT:
					outLevel <= ctl[tctf_pkg::CC_OUTVAL_BIT];
				tctf_pkg::OUT_TOGGLE:
					outLevel <= outLevel ^ cmpHit;
				tctf_pkg::OUT_RSTSET:
					if (cmpHit)
						outLevel <= 1'b0;
					else if (wrapPulse)
						outLevel <= 1'b1;
				default:
					if (cmpHit)
						outLevel <= 1'b1;
					else if (wrapPulse)
						outLevel <= 1'b0;
			endcase
	end

endmodule

// ---- verification/tctf_fabric_checker.sv ----
`timescale 1ns/1ps
module tctf_fabric_checker
(
	// clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// register bus handshakes
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// triggers and pads
	input wire logic        comparatorOutput,
	input wire logic        hizTriggerPin,
	input wire logic [3:0]  pinFunctionSelect,
	input wire logic [3:0]  padOutEnable,
	input wire logic        wakeEvent
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);

	a_ready_pair: assert property (s_axi_awready == s_axi_wready)
		else $error("write readies differ");
	a_write_resp: assert property ($rose(s_axi_awready) |=> s_axi_bvalid)
		else $error("write response late");
	a_read_resp: assert property ($rose(s_axi_arready) |=> s_axi_rvalid)
		else $error("read data late");
	a_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data held after accept");
	a_hiz_kill: assert property (
		(comparatorOutput && hizTriggerPin) [*4] |-> padOutEnable == 4'h0)
		else $error("pads not released under trigger");
	a_hiz_release: assert property (
		(!comparatorOutput && !hizTriggerPin) [*4]
		|-> padOutEnable == $past(pinFunctionSelect))
		else $error("pad enables not restored");
	a_oe_select: assert property (
		(padOutEnable & ~$past(pinFunctionSelect)) == 4'h0)
		else $error("pad driven without function select");
	a_wake_pulse: assert property (wakeEvent |=> !wakeEvent)
		else $error("wake event wider than one cycle");
endmodule

bind tctf_fabric tctf_fabric_checker chk (.clk, .reset, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .comparatorOutput, .hizTriggerPin, .pinFunctionSelect,
	.padOutEnable, .wakeEvent);

// ---- verification/tctf_far_side.sv ----
`timescale 1ns/1ps
module tctf_far_side
(
	// system clock
	input wire logic clk,
	// source clocks, each level held two cycles or more for the synchronisers
	output logic     externalTimerClock,
	output logic     auxClock,
	output logic     subsystemClock,
	output logic     touchBlockClock
);
	logic [4:0] divCount = 5'h00;

	always @(posedge clk)
		divCount <= divCount + 5'h01;

	assign externalTimerClock = divCount[1];
	assign auxClock = divCount[2];
	assign subsystemClock = divCount[3];
	assign touchBlockClock = divCount[4];
endmodule

// ---- verification/timer_capture_trigger_fabric_tb_top.sv ----
`timescale 1ns/1ps
module timer_capture_trigger_fabric_tb_top;
	logic        clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, comparatorOutput;
	logic        externalTimerClock, auxClock, subsystemClock, touchBlockClock;
	logic        ch1PinGroup0, ch1PinGroup1, ch2PinGroup0, ch2PinGroup1;
	logic        hizTriggerPin, touchCapture, serialTxData, irTxOut;
	logic        convTrigger, wakeEvent, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb, pinFunctionSelect, padOut, padOutEnable;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          mismatches = 0;
	int          check_count = 0;
	int          cycles = 0;
	int          convCnt = 0;
	int          wakeCnt = 0;

	tctf_fabric uut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.externalTimerClock, .auxClock, .subsystemClock, .touchBlockClock,
		.ch1PinGroup0, .ch1PinGroup1, .ch2PinGroup0, .ch2PinGroup1,
		.comparatorOutput, .hizTriggerPin, .touchCapture, .pinFunctionSelect,
		.serialTxData, .padOut, .padOutEnable, .irTxOut, .convTrigger,
		.wakeEvent, .irq);

	tctf_far_side far (.clk, .externalTimerClock, .auxClock, .subsystemClock,
		.touchBlockClock);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task give_verdict;
		if (mismatches == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// pulses are counted with non-blocking updates so tasks read a stable value
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (convTrigger === 1'b1)
			convCnt <= convCnt + 1;
		if (wakeEvent === 1'b1)
			wakeCnt <= wakeCnt + 1;
		if (cycles == 30000)
		begin
			mismatches = mismatches + 1;
			give_verdict();
		end
	end

	task check(input string what, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = 2'h0);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// no local limit: only the bench timeout ends a hung wait
		while (s_axi_awready !== 1'b1)
			@(posedge clk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (s_axi_bvalid !== 1'b1)
			@(posedge clk);
		s_axi_bready <= 1'b0;
		check("bresp", s_axi_bresp, er);
	endtask

	task axi_rd(input logic [7:0] a, input logic [1:0] er = 2'h0);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (s_axi_arready !== 1'b1)
			@(posedge clk);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1)
			@(posedge clk);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		check("rresp", s_axi_rresp, er);
	endtask

	task test_regs;
		axi_rd(tctf_pkg::OFS_CTRL);
		check("ctrl", rd, 32'h0);
		axi_rd(tctf_pkg::OFS_WAKEMOD);
		check("wakemod", rd, 32'hFFFF);
		axi_wr(tctf_pkg::OFS_CHANNEL_ZERO_COMPARE, 32'hA5C3);
		axi_rd(tctf_pkg::OFS_CHANNEL_ZERO_COMPARE);
		check("channel_zero_compare", rd, 32'hA5C3);
		axi_rd(8'h40, 2'h2);
		check("unmapped", rd, 32'h0);
		axi_wr(tctf_pkg::OFS_COUNT, 32'h5, 2'h2);
	endtask

	task test_wrap;
		axi_wr(tctf_pkg::OFS_CHANNEL_ZERO_COMPARE, 32'h3);
		axi_wr(tctf_pkg::OFS_IRQMASK, 32'h1);
		for (int c = 0; c < 4; c++)
		begin
			axi_wr(tctf_pkg::OFS_CTRL, 32'(c * 4 + 1));
			for (int n = 0; n < 400 && irq !== 1'b1; n++)
				@(posedge clk);
			check("wrap irq", irq, 1'b1);
			axi_rd(tctf_pkg::OFS_COUNT);
			check("count", rd <= 32'h3, 1'b1);
			axi_wr(tctf_pkg::OFS_CTRL, 32'h0);
			axi_wr(tctf_pkg::OFS_IRQSTAT, 32'h1);
			repeat (2) @(posedge clk);
			check("irq clear", irq, 1'b0);
		end
	endtask

	task test_remap;
		axi_wr(tctf_pkg::OFS_CCTL1, 32'h3);
		axi_wr(tctf_pkg::OFS_IRQMASK, 32'h4);
		for (int r = 0; r < 2; r++)
		begin
			axi_wr(tctf_pkg::OFS_CTRL, 32'(r * 16));
			for (int g = 0; g < 2; g++)
			begin
				axi_wr(tctf_pkg::OFS_IRQSTAT, 32'h3F);
				{ch1PinGroup1, ch1PinGroup0} <= 2'(1 << g);
				{ch2PinGroup1, ch2PinGroup0} <= 2'(1 << g);
				repeat (6) @(posedge clk);
				{ch1PinGroup1, ch1PinGroup0} <= 2'b00;
				{ch2PinGroup1, ch2PinGroup0} <= 2'b00;
				repeat (6) @(posedge clk);
				check("capture", irq, 1'(g == r));
			end
		end
	endtask

	task hiz(input logic [1:0] s, input logic [3:0] e);
		{hizTriggerPin, comparatorOutput} <= s;
		repeat (4) @(posedge clk);
		check("hiz", padOutEnable, e);
	endtask

	task test_hiz;
		axi_wr(tctf_pkg::OFS_CCTL0, 32'h80);
		axi_wr(tctf_pkg::OFS_CCTL1, 32'h80);
		axi_wr(tctf_pkg::OFS_CTRL, 32'h0);
		pinFunctionSelect <= 4'hF;
		repeat (4) @(posedge clk);
		check("oe", padOutEnable, 4'hF);
		check("pads", padOut, 4'h5);
		hiz(2'b01, 4'h0);
		hiz(2'b10, 4'hF);
		axi_wr(tctf_pkg::OFS_CTRL, 32'h20);
		hiz(2'b10, 4'h0);
		hiz(2'b11, 4'h0);
		hiz(2'b00, 4'hF);
	endtask

	// each entry: expected, serial data, channel one level, ir config
	task test_ir;
		logic [7:0] t [9] = '{8'hC0, 8'h00, 8'hB9, 8'h19, 8'h3B,
			8'h1D, 8'h8D, 8'hE1, 8'h21};
		axi_wr(tctf_pkg::OFS_CCTL2, 32'h80);
		foreach (t[i])
		begin
			serialTxData <= t[i][6];
			axi_wr(tctf_pkg::OFS_CCTL1, {24'h0, t[i][5], 7'h0});
			axi_wr(tctf_pkg::OFS_IRCFG, {27'h0, t[i][4:0]});
			repeat (4) @(posedge clk);
			check("ir", irTxOut, t[i][7]);
		end
	endtask

	task test_conv;
		int b;
		int w;
		b = convCnt;
		axi_wr(tctf_pkg::OFS_CTRL, 32'h400);
		repeat (4) @(posedge clk);
		check("sw start", convCnt - b, 1);
		comparatorOutput <= 1'b1;
		axi_wr(tctf_pkg::OFS_CTRL, 32'h300);
		repeat (4) @(posedge clk);
		check("conv cmp", convTrigger, 1'b1);
		comparatorOutput <= 1'b0;
		repeat (4) @(posedge clk);
		check("conv cmp low", convTrigger, 1'b0);
		axi_wr(tctf_pkg::OFS_CTRL, 32'h200);
		repeat (4) @(posedge clk);
		check("conv ch1", convTrigger, 1'b1);
		// drop the channel one level so it adds no counts below
		axi_wr(tctf_pkg::OFS_CCTL1, 32'h0);
		axi_wr(tctf_pkg::OFS_WAKEMOD, 32'h2);
		b = convCnt;
		w = wakeCnt;
		axi_wr(tctf_pkg::OFS_CTRL, 32'h180);
		repeat (96) @(posedge clk);
		check("wake aux", (wakeCnt - w) inside {[3:5]}, 1);
		check("conv wake", convCnt - b, wakeCnt - w);
		// stop the aux-clocked counter and let its last pulse drain
		axi_wr(tctf_pkg::OFS_CTRL, 32'h0);
		@(posedge clk);
		b = convCnt;
		w = wakeCnt;
		axi_wr(tctf_pkg::OFS_CTRL, 32'h0C0);
		repeat (96) @(posedge clk);
		check("wake sub", (wakeCnt - w) inside {[1:3]}, 1);
		check("conv idle", convCnt - b, 0);
	endtask

	initial
	begin
		reset = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, serialTxData, touchCapture} = 4'h0;
		{ch1PinGroup0, ch1PinGroup1, ch2PinGroup0, ch2PinGroup1} = 4'h0;
		{comparatorOutput, hizTriggerPin} = 2'h0;
		{s_axi_awaddr, s_axi_araddr} = 16'h0000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		pinFunctionSelect = 4'h0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		test_regs();
		test_wrap();
		test_remap();
		test_hiz();
		test_ir();
		test_conv();
		give_verdict();
	end
endmodule
